// ### bench/oc_compare_checker.sv
// Port-level assertions for the compare unit, bound to its top module.
// Assumes the core clock and the active-low asynchronous reset of the unit.
`include "oc_defines.svh"
module oc_compare_checker (
  input wire logic        i_core_clk,
  input wire logic        i_rst_b,
  input wire logic        i_tick,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_channel_output_state,
  input wire logic        o_compare_match_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Decoded writes
  logic frc;
  logic pwm;
  logic clr;
  assign frc = i_psel && i_penable && i_pwrite && i_paddr == `OC_ADDR_CONTROL && i_pwdata[7];
  assign pwm = !(i_pwdata[5:2] inside {4'h0, 4'h4, 4'hC});
  assign clr = i_psel && i_penable && i_pwrite && i_paddr == `OC_ADDR_STATUS && i_pwdata[0];

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);

  // ==========================================================================
  // Assertions
  a_ready_access: assert property (i_psel && i_penable |-> o_pready)
    else $error("no ready in access cycle");
  a_ready_only: assert property (o_pready |-> i_psel && i_penable)
    else $error("ready outside access cycle");
  a_err_reads_zero: assert property (o_pslverr && !i_pwrite |-> o_pready && o_prdata == 32'h0000_0000)
    else $error("refused read not zero");
  a_flag_on_tick: assert property ($rose(o_compare_match_flag) |-> $past(i_tick))
    else $error("flag set without timer tick");
  a_flag_clear_cause: assert property ($fell(o_compare_match_flag) |-> $past(clr) || $past(clr, 2))
    else $error("flag cleared without write");
  a_state_cause: assert property ($changed(o_channel_output_state) |->
    $past(i_tick) || $past(i_tick, 2) || $past(frc, 2) || $past(frc, 3))
    else $error("output state changed without cause");
  a_force_sets: assert property (frc && !pwm && i_pwdata[1:0] == 2'b11 |->
    ##[2:3] o_channel_output_state)
    else $error("force did not set output");
  a_force_clears: assert property (frc && !pwm && i_pwdata[1:0] == 2'b10 |->
    ##[2:3] !o_channel_output_state)
    else $error("force did not clear output");
  a_force_pwm_idle: assert property ((frc && pwm && !i_tick) ##1 (!i_tick) [*3] |->
    o_channel_output_state == $past(o_channel_output_state, 3))
    else $error("force acted in pwm mode");
endmodule // oc_compare_checker

bind oc_compare_unit oc_compare_checker oc_compare_checker_inst (
  .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_tick(i_tick), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_channel_output_state(o_channel_output_state), .o_compare_match_flag(o_compare_match_flag));

// ### bench/tb_top.sv
// Self-checking bench for the compare unit: access, forcing, blocking, buffering.
// Assumes the package, the defines header and the unit are compiled first.
`include "oc_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_core_clk = 1'b0;
  logic        i_rst_b    = 1'b0;
  logic        i_tick     = 1'b0;
  logic        i_psel     = 1'b0;
  logic        i_penable  = 1'b0;
  logic        i_pwrite   = 1'b0;
  logic [11:0] i_paddr    = 12'h000;
  logic [31:0] i_pwdata   = 32'h0000_0000;
  logic [31:0] o_prdata;
  logic        o_pready;
  logic        o_pslverr;
  logic        o_channel_output_state;
  logic        o_compare_match_flag;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  always #5 i_core_clk = ~i_core_clk;

  oc_compare_unit oc_compare_unit_inst (
    .i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_tick(i_tick), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .o_channel_output_state(o_channel_output_state), .o_compare_match_flag(o_compare_match_flag));

  // ==========================================================================
  // Shared tasks
  task automatic complete_run();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The whole run needs about two hundred cycles, so this ceiling only cuts a hang.
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    i_psel   <= 1'b1;
    i_pwrite <= wr;
    i_paddr  <= a;
    i_pwdata <= d;
    @(posedge i_core_clk);
    i_penable <= 1'b1;
    do begin
      @(posedge i_core_clk);
    end while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel    <= 1'b0;
    i_penable <= 1'b0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_core_clk);
      i_tick <= 1'b1;
      @(posedge i_core_clk);
      i_tick <= 1'b0;
    end
    repeat (2) @(posedge i_core_clk);
  endtask

  function automatic logic [31:0] ctlw(input logic [1:0] act, input logic [3:0] mode,
                                       input logic run, input logic frc);
    return {24'h00_0000, frc, run, mode, act};
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    chk({31'h0, o_channel_output_state}, 32'h0000_0000);
    rdc(`OC_ADDR_TOP, 32'h0000_00FF);
    bus(1'b0, 12'h020, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
  endtask

  task automatic t_access();
    bus(1'b1, `OC_ADDR_CONTROL, ctlw(2'h0, 4'h0, 1'b0, 1'b0));
    bus(1'b1, `OC_ADDR_CMP_HIGH, 32'h0000_0012);
    rdc(`OC_ADDR_CMP_VALUE, 32'h0000_0000);
    bus(1'b1, `OC_ADDR_CMP_LOW, 32'h0000_0034);
    rdc(`OC_ADDR_CMP_VALUE, 32'h0000_1234);
    rdc(`OC_ADDR_CMP_LIVE, 32'h0000_1234);
    bus(1'b1, `OC_ADDR_CMP_LOW, 32'h0000_0056);
    rdc(`OC_ADDR_CMP_VALUE, 32'h0000_1256);
  endtask

  task automatic t_force();
    logic [1:0] act[5];
    logic       exp[5];
    act = '{oc_pkg::ACT_SET, oc_pkg::ACT_NONE, oc_pkg::ACT_CLEAR, oc_pkg::ACT_TOGGLE,
            oc_pkg::ACT_TOGGLE};
    exp = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    for (int i = 0; i < 5; i++) begin
      bus(1'b1, `OC_ADDR_CONTROL, ctlw(act[i], 4'h0, 1'b0, 1'b1));
      repeat (3) @(posedge i_core_clk);
      chk({31'h0, o_channel_output_state}, {31'h0, exp[i]});
      chk({31'h0, o_compare_match_flag}, 32'h0000_0000);
    end
    rdc(`OC_ADDR_COUNTER, 32'h0000_0000);
  endtask

  task automatic t_mode();
    bus(1'b1, `OC_ADDR_CONTROL, ctlw(2'h3, 4'h0, 1'b0, 1'b1));
    bus(1'b1, `OC_ADDR_CONTROL, ctlw(2'h2, 4'h5, 1'b0, 1'b1));
    repeat (3) @(posedge i_core_clk);
    chk({31'h0, o_channel_output_state}, 32'h0000_0001);
    bus(1'b1, `OC_ADDR_CONTROL, ctlw(2'h0, 4'h0, 1'b0, 1'b0));
    repeat (3) @(posedge i_core_clk);
    chk({31'h0, o_channel_output_state}, 32'h0000_0001);
  endtask

  task automatic t_block();
    bus(1'b1, `OC_ADDR_CMP_LOW, 32'h0000_0034);
    bus(1'b1, `OC_ADDR_CONTROL, ctlw(2'h1, 4'h0, 1'b0, 1'b0));
    bus(1'b1, `OC_ADDR_COUNTER, 32'h0000_1234);
    ticks(2);
    chk({31'h0, o_channel_output_state}, 32'h0000_0001);
    bus(1'b1, `OC_ADDR_CONTROL, ctlw(2'h1, 4'h0, 1'b1, 1'b0));
    ticks(3);
    chk({31'h0, o_compare_match_flag}, 32'h0000_0000);
    chk({31'h0, o_channel_output_state}, 32'h0000_0001);
    bus(1'b1, `OC_ADDR_COUNTER, 32'h0000_1232);
    ticks(4);
    chk({31'h0, o_compare_match_flag}, 32'h0000_0001);
    chk({31'h0, o_channel_output_state}, 32'h0000_0000);
    bus(1'b1, `OC_ADDR_STATUS, 32'h0000_0001);
    repeat (2) @(posedge i_core_clk);
    chk({31'h0, o_compare_match_flag}, 32'h0000_0000);
  endtask

  task automatic t_buffer();
    bus(1'b1, `OC_ADDR_CONTROL, ctlw(2'h0, 4'h5, 1'b0, 1'b0));
    bus(1'b1, `OC_ADDR_CMP_HIGH, 32'h0000_0000);
    bus(1'b1, `OC_ADDR_CMP_LOW, 32'h0000_0080);
    rdc(`OC_ADDR_CMP_VALUE, 32'h0000_0080);
    rdc(`OC_ADDR_CMP_LIVE, 32'h0000_1234);
    bus(1'b1, `OC_ADDR_COUNTER, 32'h0000_00FE);
    bus(1'b1, `OC_ADDR_CONTROL, ctlw(2'h0, 4'h5, 1'b1, 1'b0));
    ticks(4);
    rdc(`OC_ADDR_CMP_LIVE, 32'h0000_0080);
  endtask

  task automatic t_vartop();
    bus(1'b1, `OC_ADDR_CONTROL, ctlw(2'h0, 4'hE, 1'b0, 1'b0));
    bus(1'b1, `OC_ADDR_TOP, 32'h0000_0010);
    bus(1'b1, `OC_ADDR_COUNTER, 32'h0000_0010);
    bus(1'b1, `OC_ADDR_CONTROL, ctlw(2'h0, 4'hE, 1'b1, 1'b0));
    ticks(2);
    bus(1'b1, `OC_ADDR_CONTROL, ctlw(2'h0, 4'hE, 1'b0, 1'b0));
    rdc(`OC_ADDR_COUNTER, 32'h0000_0012);
  endtask

  initial begin
    repeat (16) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    t_reset();
    t_access();
    t_force();
    t_mode();
    t_block();
    t_buffer();
    t_vartop();
    complete_run();
  end
endmodule // tb_top

// ### src/oc_compare_unit.sv
// Output compare channel of a 16-bit timer with an APB register port.
// Assumes one core clock, an active-low asynchronous reset and a 32-bit APB master.
//
// The placing of the registers and the APB register port are this design's own decisions.
`include "oc_defines.svh"

// Functional notes
// - Compare accesses hit the buffer when double buffered, else the live register; OC_ADDR_CMP_LIVE reads always return the live one.
// - The compare value changes only by processor writes or the buffered transfer.
// - Compare reads return both bytes directly, not via the high-byte latch.
// - A high-byte write loads only the shared high-byte latch.
// - A low-byte write stores it plus the latched high byte in one cycle.
// - In non-PWM modes a force strobe makes a compare match event.
// - A forced match sets no flag and leaves the counter alone.
// - A forced match sets, clears or toggles the output as selected.
// - A counter write blocks every match in the next timer cycle.
// - Writing the counter equal to the compare value loses that match.
// - Counter written to variable TOP outside mode 4 skips that TOP and runs to 0xFFFF.
// - The output state keeps its value across mode changes.
// - Action bits are not buffered and take effect at once.
// - Double buffering is on in PWM modes, off in normal and CLEAR_ON_COMPARE_MODE.
// - The buffered value moves to the live register only at TOP or BOTTOM.
// - Reset clears the output state.
module oc_compare_unit (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_tick,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic             o_channel_output_state,
  output logic             o_compare_match_flag
);

  // ========================================================================
  // Declarations
  logic [15:0]         compare_value_reg_r;
  logic [15:0]         compare_buffer_r;
  logic [7:0]          high_latch_r;
  logic [15:0]         counter_value_reg_r;
  logic [15:0]         top_r;
  logic [1:0]          action_r;
  logic [3:0]          waveform_mode_select_r;
  logic                run_r;
  logic                count_up_r;
  logic                block_r;
  logic                match_pend_r;
  logic                flag_r;
  logic                force_r;
  logic [31:0]         prdata_r;
  logic                pready_r;
  logic                pslverr_r;
  logic                out_state;
  logic                pwm;
  logic                dbuf;
  logic                phase;
  logic                at_top;
  logic                at_bottom;
  logic                wr_acc;
  logic                rd_acc;
  logic                cnt_wr;
  logic                match;
  logic                flag_clr;
  logic [15:0]         mode_top;
  logic                var_top;
  logic                tmr_tick;
  logic                wave_event;
  oc_pkg::mode_class_t cls;

  // ========================================================================
  // Mode decode
  function automatic oc_pkg::mode_class_t mode_class(input logic [3:0] m);
    unique case (m)
      4'h0:                      mode_class = oc_pkg::CLS_NORMAL;
      4'h4, 4'hC:                mode_class = oc_pkg::CLS_CTC;
      4'h5, 4'h6, 4'h7, 4'hE, 4'hF: mode_class = oc_pkg::CLS_FAST;
      default:                   mode_class = oc_pkg::CLS_PHASE;
    endcase
  endfunction

  assign cls   = mode_class(waveform_mode_select_r);
  assign pwm   = (cls == oc_pkg::CLS_FAST) || (cls == oc_pkg::CLS_PHASE);
  assign phase = (cls == oc_pkg::CLS_PHASE);
  assign dbuf  = pwm;

  // Fixed TOP for the 8/9/10-bit modes; the TOP register serves modes 8, A, C, D, E, the compare value modes 4, 9, B, F.
  always_comb begin
    var_top  = 1'b0;
    mode_top = top_r;
    unique case (waveform_mode_select_r)
      4'h0:       mode_top = `OC_COUNT_MAX;
      4'h1, 4'h5: mode_top = `OC_TOP_8BIT;
      4'h2, 4'h6: mode_top = `OC_TOP_9BIT;
      4'h3, 4'h7: mode_top = `OC_TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: mode_top = compare_value_reg_r;
      default:    var_top  = 1'b1;
    endcase
    if (waveform_mode_select_r == 4'h9 || waveform_mode_select_r == 4'hB ||
        waveform_mode_select_r == 4'hF) begin
      var_top = 1'b1;
    end
  end

  assign at_top    = (counter_value_reg_r == mode_top);
  assign at_bottom = (counter_value_reg_r == `OC_COUNT_BOTTOM);

  // ========================================================================
  // Timer cycle
  // The run bit gates the tick, so a stopped timer keeps a pending block for its restart.
  assign tmr_tick = i_tick && run_r;

  // ========================================================================
  // APB decode
  assign wr_acc   = i_psel && i_penable && i_pwrite && pready_r;
  assign rd_acc   = i_psel && !i_penable && !i_pwrite;
  assign cnt_wr   = wr_acc && (i_paddr == `OC_ADDR_COUNTER);
  assign flag_clr = wr_acc && (i_paddr == `OC_ADDR_STATUS) && i_pwdata[`OC_STS_FLAG_BIT];

  // A counter write blocks matches in the next timer cycle, even when the tick is held off.
  assign match = (counter_value_reg_r == compare_value_reg_r) && !block_r;

  // ========================================================================
  // Compare registers
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      high_latch_r <= 8'h00;
    end else if (wr_acc && i_paddr == `OC_ADDR_CMP_HIGH) begin
      high_latch_r <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      compare_buffer_r <= `OC_RST_WORD16;
    end else if (wr_acc && i_paddr == `OC_ADDR_CMP_LOW && dbuf) begin
      compare_buffer_r <= {high_latch_r, i_pwdata[7:0]};
    end
  end

  // Only processor writes or the buffered transfer move it; the counter never does.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      compare_value_reg_r <= `OC_RST_WORD16;
    end else if (wr_acc && i_paddr == `OC_ADDR_CMP_LOW && !dbuf) begin
      compare_value_reg_r <= {high_latch_r, i_pwdata[7:0]};
    end else if (dbuf && tmr_tick && (phase ? at_top : at_bottom)) begin
      compare_value_reg_r <= compare_buffer_r;
    end
  end

  // ========================================================================
  // Control
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      action_r               <= 2'b00;
      waveform_mode_select_r <= 4'h0;
      run_r                  <= 1'b0;
      top_r                  <= `OC_RST_TOP;
    end else if (wr_acc && i_paddr == `OC_ADDR_CONTROL) begin
      action_r               <= i_pwdata[`OC_CTL_ACTION_LSB +: 2];
      waveform_mode_select_r <= i_pwdata[`OC_CTL_MODE_LSB +: 4];
      run_r                  <= i_pwdata[`OC_CTL_RUN_BIT];
    end else if (wr_acc && i_paddr == `OC_ADDR_TOP) begin
      top_r <= i_pwdata[15:0];
    end
  end

  // Strobe lives one cycle only and is dropped in PWM modes.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      force_r <= 1'b0;
    end else begin
      force_r <= wr_acc && i_paddr == `OC_ADDR_CONTROL && i_pwdata[`OC_CTL_FORCE_BIT] &&
                 !(mode_class(i_pwdata[`OC_CTL_MODE_LSB +: 4]) inside
                   {oc_pkg::CLS_FAST, oc_pkg::CLS_PHASE});
    end
  end

  // ========================================================================
  // Counter
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      counter_value_reg_r <= `OC_RST_WORD16;
      count_up_r          <= 1'b1;
    end else if (cnt_wr) begin
      counter_value_reg_r <= i_pwdata[15:0];
    end else if (tmr_tick) begin
      if (phase) begin
        if (count_up_r && at_top && !block_r) begin
          count_up_r          <= 1'b0;
          counter_value_reg_r <= counter_value_reg_r - 16'h0001;
        end else if (!count_up_r && at_bottom) begin
          count_up_r          <= 1'b1;
          counter_value_reg_r <= counter_value_reg_r + 16'h0001;
        end else begin
          counter_value_reg_r <= count_up_r ? counter_value_reg_r + 16'h0001
                                            : counter_value_reg_r - 16'h0001;
        end
      // A counter written to a variable TOP outside mode 4 skips that wrap and runs on to the maximum.
      end else if (at_top && cls != oc_pkg::CLS_NORMAL && !(var_top && block_r)) begin
        counter_value_reg_r <= `OC_COUNT_BOTTOM;
      end else begin
        counter_value_reg_r <= counter_value_reg_r + 16'h0001;
        count_up_r          <= 1'b1;
      end
    end
  end

  // The block holds until the next timer tick has been consumed.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      block_r <= 1'b0;
    end else if (cnt_wr) begin
      block_r <= 1'b1;
    end else if (tmr_tick) begin
      block_r <= 1'b0;
    end
  end

  // ========================================================================
  // Match flag
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      match_pend_r <= 1'b0;
    end else if (tmr_tick) begin
      match_pend_r <= match;
    end
  end

  // Setting wins over a simultaneous software clear; a force never sets it.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      flag_r <= 1'b0;
    end else if (tmr_tick && match_pend_r) begin
      flag_r <= 1'b1;
    end else if (flag_clr) begin
      flag_r <= 1'b0;
    end
  end

  // ========================================================================
  // Output state
  // A force reaches the output one cycle after its write, as the strobe is registered.
  // Forced events never touch the flag path, which only follows real matches.
  assign wave_event = (tmr_tick && match) || force_r;

  oc_wave_action oc_wave_action_inst (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_event    (wave_event),
    .i_up       (count_up_r),
    .i_pwm      (phase),
    .i_action   (oc_pkg::action_t'(action_r)),
    .o_state    (out_state)
  );

  // ========================================================================
  // APB answer
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= i_psel && !i_penable;
      pslverr_r <= i_psel && !i_penable && (i_paddr > `OC_ADDR_TOP || i_paddr[1:0] != 2'b00);
      if (rd_acc) begin
        unique case (i_paddr)
          `OC_ADDR_CMP_HIGH:  prdata_r <= {24'h00_0000,
                                           dbuf ? compare_buffer_r[15:8]
                                                : compare_value_reg_r[15:8]};
          `OC_ADDR_CMP_LOW:   prdata_r <= {24'h00_0000,
                                           dbuf ? compare_buffer_r[7:0]
                                                : compare_value_reg_r[7:0]};
          `OC_ADDR_CMP_VALUE: prdata_r <= {16'h0000,
                                           dbuf ? compare_buffer_r : compare_value_reg_r};
          `OC_ADDR_COUNTER:   prdata_r <= {16'h0000, counter_value_reg_r};
          `OC_ADDR_CONTROL:   prdata_r <= {25'h000_0000, run_r, waveform_mode_select_r,
                                           action_r};
          `OC_ADDR_STATUS:    prdata_r <= {29'h0000_0000, count_up_r, out_state, flag_r};
          `OC_ADDR_CMP_LIVE:  prdata_r <= {16'h0000, compare_value_reg_r};
          `OC_ADDR_TOP:       prdata_r <= {16'h0000, top_r};
          default:            prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign o_prdata               = prdata_r;
  assign o_pready               = pready_r;
  assign o_pslverr              = pslverr_r;
  assign o_channel_output_state = out_state;
  assign o_compare_match_flag   = flag_r;

endmodule // oc_compare_unit

// ### src/oc_defines.svh
// Register offsets, field positions, reset values and limits of the compare unit.
// Assumes an APB slave with 32-bit data, one aligned word per register.
`ifndef OC_DEFINES_SVH
`define OC_DEFINES_SVH

// ==========================================================================
// Register byte offsets
`define OC_ADDR_CMP_HIGH   12'h000
`define OC_ADDR_CMP_LOW    12'h004
`define OC_ADDR_CMP_VALUE  12'h008
`define OC_ADDR_COUNTER    12'h00C
`define OC_ADDR_CONTROL    12'h010
`define OC_ADDR_STATUS     12'h014
`define OC_ADDR_CMP_LIVE   12'h018
`define OC_ADDR_TOP        12'h01C

// ==========================================================================
// Control fields
`define OC_CTL_ACTION_LSB  0
`define OC_CTL_MODE_LSB    2
`define OC_CTL_RUN_BIT     6
`define OC_CTL_FORCE_BIT   7

// ==========================================================================
// Status fields
`define OC_STS_FLAG_BIT    0
`define OC_STS_STATE_BIT   1
`define OC_STS_DIR_BIT     2

// ==========================================================================
// Reset values and limits
`define OC_RST_WORD16      16'h0000
`define OC_RST_TOP         16'h00FF
`define OC_COUNT_MAX       16'hFFFF
`define OC_COUNT_BOTTOM    16'h0000
`define OC_TOP_8BIT        16'h00FF
`define OC_TOP_9BIT        16'h01FF
`define OC_TOP_10BIT       16'h03FF

`endif

// ### src/oc_pkg.sv
// Types shared by the compare unit files.
// Assumes the defines header for all numeric constants.
package oc_pkg;

  // ========================================================================
  // Compare output actions
  typedef enum logic [1:0] {
    ACT_NONE   = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_CLEAR  = 2'b10,
    ACT_SET    = 2'b11
  } action_t;

  // ========================================================================
  // Waveform mode classes
  typedef enum logic [1:0] {
    CLS_NORMAL = 2'b00,
    CLS_CTC    = 2'b01,
    CLS_FAST   = 2'b10,
    CLS_PHASE  = 2'b11
  } mode_class_t;

endpackage

// ### src/oc_wave_action.sv
// Applies a compare output action to the channel output state.
// Assumes match and force pulses from the same clock domain.
module oc_wave_action (
  input  wire logic            i_core_clk,
  input  wire logic            i_rst_b,
  input  wire logic            i_event,
  input  wire logic            i_up,
  input  wire logic            i_pwm,
  input  wire oc_pkg::action_t i_action,
  output logic                 o_state
);

  logic state_r;
  logic state_nxt;

  // ========================================================================
  // Next state
  // In phase-correct PWM modes clear and set invert on the down slope so pulses stay symmetric.
  always_comb begin
    state_nxt = state_r;
    if (i_event) begin
      unique case (i_action)
        oc_pkg::ACT_NONE:   state_nxt = state_r;
        oc_pkg::ACT_TOGGLE: state_nxt = ~state_r;
        oc_pkg::ACT_CLEAR:  state_nxt = (i_pwm && !i_up) ? 1'b1 : 1'b0;
        oc_pkg::ACT_SET:    state_nxt = (i_pwm && !i_up) ? 1'b0 : 1'b1;
      endcase
    end
  end

  // State is untouched by mode changes; only events move it.
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign o_state = state_r;

endmodule // oc_wave_action
